// ===== design/dbg_cmd_exec.sv
// Debug command executor: register access, memory access, dump and fill.
//
// The placing of the registers and the Wishbone register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "dbg_cmd_cfg.svh"
module dbg_cmd_exec
(
  input  wire logic                  CLK,
  input  wire logic                  RST_B,
  input  wire logic                  XFER_STROBE,
  input  wire logic [16:0]           XFER_IN,
  output var  logic [16:0]           XFER_OUT,
  output var  dbg_cmd_pkg::mem_req_t MEM_REQ,
  input  wire dbg_cmd_pkg::mem_rsp_t MEM_RSP,
  input  wire logic                  WB_CYC_I,
  input  wire logic                  WB_STB_I,
  input  wire logic                  WB_WE_I,
  input  wire logic [7:0]            WB_ADR_I,
  input  wire logic [3:0]            WB_SEL_I,
  input  wire logic [31:0]           WB_DAT_I,
  output var  logic [31:0]           WB_DAT_O,
  output var  logic                  WB_ACK_O
);
  import dbg_cmd_pkg::*;

  logic              strobe_pulse;
  logic [16:0]       in_word;
  cmd_state_t        state_q;
  cmd_op_t           op_q;
  logic [1:0]        size_q;
  logic [3:0]        sel_q;
  logic [15:0]       hi_q;
  logic [31:0]       addr_q;
  logic [31:0]       result_q;
  logic              err_q;
  logic [31:0]       core_q [16];
  logic [31:0]       rpc_q;
  logic [31:0]       pcc_q;
  logic [31:0]       scra_q;
  logic [31:0]       fault_q;
  logic [31:0]       vbase_q;
  logic [15:0]       psw_q;
  logic [31:0]       usp_q;
  logic [31:0]       ssp_q;
  logic [2:0]        sfc_q;
  logic [2:0]        dfc_q;
  logic              busy_q;
  logic [31:0]       cmd_count_q;
  logic [16:0]       xfer_out_d;
  cmd_op_t           dec_op;
  logic [31:0]       sys_rd;
  logic [31:0]       op_data;
  logic [16:0]       in_meta_q;
  logic [16:0]       in_sync_q;
  logic [31:0]       rd_fmt;

  // The link strobe comes from the host's clock, so it is synchronised first.
  dbg_link_sync u_sync
  (
    .CLK        (CLK),
    .RST_B      (RST_B),
    .async_in   (XFER_STROBE),
    .rise_pulse (strobe_pulse)
  );

  // The data word crosses from the host's clock as well, so it takes the same two stages.
  // It stands still around the strobe, so the delayed copy is valid when the pulse arrives.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      in_meta_q <= 17'h0_0000;
      in_sync_q <= 17'h0_0000;
    end
    else
    begin
      in_meta_q <= XFER_IN;
      in_sync_q <= in_meta_q;
    end
  end

  // Only the second stage is read by the decoder and the operand path.
  assign in_word = in_sync_q;

  // Step for the pointer from the size code.
  function automatic logic [31:0] size_step(input logic [1:0] sz);
    unique case (sz)
      `SZ_BYTE: size_step = 32'h0000_0001;
      `SZ_WORD: size_step = 32'h0000_0002;
      default:  size_step = 32'h0000_0004;
    endcase
  endfunction

  // Result packing for memory reads; byte data is zero extended.
  function automatic logic [31:0] fmt_read(input logic [1:0] sz, input logic [31:0] d);
    unique case (sz)
      `SZ_BYTE: fmt_read = {24'h00_0000, d[7:0]};
      `SZ_WORD: fmt_read = {16'h0000, d[15:0]};
      default:  fmt_read = d;
    endcase
  endfunction

  // Decode the command word; unmatched words become no operation.
  always_comb
  begin
    dec_op = OP_NONE;
    if (in_word[15:4] == `CMD_RCORE_HI)
      dec_op = OP_RCORE;
    else if (in_word[15:4] == `CMD_WCORE_HI)
      dec_op = OP_WCORE;
    else if (in_word[15:4] == `CMD_RSYS_HI)
      dec_op = OP_RSYS;
    else if (in_word[15:4] == `CMD_WSYS_HI)
      dec_op = OP_WSYS;
    else if (in_word[5:0] == 6'h00)
    begin
      if (in_word[15:8] == `CMD_MRD_HI)
        dec_op = OP_MRD;
      else if (in_word[15:8] == `CMD_MWR_HI)
        dec_op = OP_MWR;
      else if (in_word[15:8] == `CMD_DUMP_HI)
        dec_op = OP_DUMP;
      else if (in_word[15:8] == `CMD_FILL_HI)
        dec_op = OP_FILL;
    end
  end

  // System register read mux, zero extended to 32 bits.
  always_comb
  begin
    sys_rd = 32'h0000_0000;
    unique case (sel_q)
      `SREG_RPC:   sys_rd = rpc_q;
      `SREG_PCC:   sys_rd = pcc_q;
      `SREG_SCRA:  sys_rd = scra_q;
      `SREG_FAULT: sys_rd = fault_q;
      `SREG_VBASE: sys_rd = vbase_q;
      `SREG_PSW:   sys_rd = {16'h0000, psw_q};
      `SREG_USP:   sys_rd = usp_q;
      `SREG_SSP:   sys_rd = ssp_q;
      `SREG_SFC:   sys_rd = {29'h0000_0000, sfc_q};
      `SREG_DFC:   sys_rd = {29'h0000_0000, dfc_q};
      default:     sys_rd = 32'h0000_0000;
    endcase
  end

  // Long operand assembled high word first.
  assign op_data = {hi_q, in_word[15:0]};

  // Memory read data packed to the result format of the current size.
  assign rd_fmt = fmt_read(size_q, MEM_RSP.rdata);

  // Command sequencer; a read register is any of the sixteen of the core file.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state_q    <= ST_IDLE;
      op_q       <= OP_NONE;
      size_q     <= 2'h0;
      sel_q      <= 4'h0;
      hi_q       <= 16'h0000;
      addr_q     <= 32'h0000_0000;
      result_q   <= 32'h0000_0000;
      err_q      <= 1'b0;
      xfer_out_d <= `STAT_DONE;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (strobe_pulse)
          begin
            op_q   <= dec_op;
            size_q <= in_word[7:6];
            sel_q  <= in_word[3:0];
            unique case (dec_op)
              OP_RCORE:
              begin
                result_q   <= core_q[in_word[3:0]];
                state_q    <= ST_RESHI;
                xfer_out_d <= `STAT_NOTREADY;
              end
              OP_RSYS:
              begin
                state_q    <= ST_RESHI;
                xfer_out_d <= `STAT_NOTREADY;
              end
              OP_DUMP:
              begin
                addr_q     <= scra_q;
                state_q    <= ST_MEM;
                xfer_out_d <= `STAT_NOTREADY;
              end
              OP_NONE:
                xfer_out_d <= (in_word[15:0] == 16'h0000) ? `STAT_DONE : `STAT_ILLEGAL;
              default:
              begin
                state_q    <= ST_OPA;
                xfer_out_d <= `STAT_NOTREADY;
              end
            endcase
          end
        end
        ST_OPA:
        begin
          if (strobe_pulse)
          begin
            hi_q <= in_word[15:0];
            // A byte or word fill carries one short operand only.
            if (op_q == OP_FILL && size_q != `SZ_LONG)
            begin
              addr_q   <= scra_q;
              result_q <= {16'h0000, in_word[15:0]};
              state_q  <= ST_MEM;
            end
            else
              state_q <= ST_OPB;
          end
        end
        ST_OPB:
        begin
          if (strobe_pulse)
          begin
            if (op_q == OP_MWR)
            begin
              addr_q  <= op_data;
              state_q <= ST_OPC;
            end
            else if (op_q == OP_MRD)
            begin
              addr_q  <= op_data;
              state_q <= ST_MEM;
            end
            else if (op_q == OP_FILL)
            begin
              addr_q   <= scra_q;
              result_q <= op_data;
              state_q  <= ST_MEM;
            end
            else
            begin
              xfer_out_d <= `STAT_DONE;
              state_q    <= ST_IDLE;
            end
          end
        end
        ST_OPC:
        begin
          if (strobe_pulse)
          begin
            hi_q <= in_word[15:0];
            if (size_q == `SZ_LONG)
              state_q <= ST_OPD;
            else
            begin
              result_q <= {16'h0000, in_word[15:0]};
              state_q  <= ST_MEM;
            end
          end
        end
        ST_OPD:
        begin
          if (strobe_pulse)
          begin
            result_q <= op_data;
            state_q  <= ST_MEM;
          end
        end
        ST_MEM:
        begin
          // The bus master is answered with an ack or an error.
          if (MEM_RSP.ack || MEM_RSP.err)
          begin
            err_q <= MEM_RSP.err;
            if (MEM_RSP.err)
            begin
              xfer_out_d <= `STAT_BUSERR;
              state_q    <= ST_IDLE;
            end
            else if (op_q == OP_MWR || op_q == OP_FILL)
            begin
              xfer_out_d <= `STAT_DONE;
              state_q    <= ST_IDLE;
            end
            else if (size_q == `SZ_LONG)
            begin
              result_q   <= rd_fmt;
              xfer_out_d <= {1'b0, rd_fmt[31:16]};
              state_q    <= ST_RESLO;
            end
            else
            begin
              // A byte or word result is one word, so it goes out on the next transfer.
              result_q   <= rd_fmt;
              xfer_out_d <= {1'b0, rd_fmt[15:0]};
              state_q    <= ST_IDLE;
            end
          end
        end
        ST_RESHI:
        begin
          // A system register read picks up its value here, once sel_q has settled.
          if (op_q == OP_RSYS)
          begin
            result_q   <= sys_rd;
            xfer_out_d <= {1'b0, sys_rd[31:16]};
          end
          else
            xfer_out_d <= {1'b0, result_q[31:16]};
          state_q <= ST_RESLO;
        end
        ST_RESLO:
        begin
          // The low word waits for the transfer that carries the high word out.
          if (strobe_pulse)
          begin
            xfer_out_d <= {1'b0, result_q[15:0]};
            state_q    <= ST_IDLE;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Pointer update; kept in the scratch register so no-ops leave it alone.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      scra_q <= 32'h0000_0000;
    else if (state_q == ST_MEM && MEM_RSP.ack && !MEM_RSP.err)
      scra_q <= addr_q + size_step(size_q);
    else if (state_q == ST_OPB && strobe_pulse && op_q == OP_WSYS && sel_q == `SREG_SCRA)
      scra_q <= op_data;
  end

  // Register writes from the link; the fault address stays read-only.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      for (int i = 0; i < 16; i++)
        core_q[i] <= 32'h0000_0000;
      rpc_q   <= 32'h0000_0000;
      pcc_q   <= 32'h0000_0000;
      vbase_q <= 32'h0000_0000;
      psw_q   <= 16'h2700;
      usp_q   <= 32'h0000_0000;
      ssp_q   <= 32'h0000_0000;
      sfc_q   <= 3'h0;
      dfc_q   <= 3'h0;
    end
    else if (state_q == ST_OPB && strobe_pulse)
    begin
      if (op_q == OP_WCORE)
        core_q[sel_q] <= op_data;
      else if (op_q == OP_WSYS)
      begin
        unique case (sel_q)
          `SREG_RPC:   rpc_q   <= op_data;
          `SREG_PCC:   pcc_q   <= op_data;
          `SREG_VBASE: vbase_q <= op_data;
          `SREG_PSW:   psw_q   <= op_data[15:0];
          `SREG_USP:   usp_q   <= op_data;
          `SREG_SSP:   ssp_q   <= op_data;
          `SREG_SFC:   sfc_q   <= op_data[2:0];
          `SREG_DFC:   dfc_q   <= op_data[2:0];
          default:     ;
        endcase
      end
    end
  end

  // Fault address is latched from the bus on every error.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      fault_q <= 32'h0000_0000;
    else if (state_q == ST_MEM && MEM_RSP.err)
      fault_q <= addr_q;
  end

  // Memory request, held from entry to the answer.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      MEM_REQ <= '0;
    else if (state_q == ST_MEM && !(MEM_RSP.ack || MEM_RSP.err))
    begin
      MEM_REQ.req   <= 1'b1;
      MEM_REQ.we    <= (op_q == OP_MWR || op_q == OP_FILL);
      MEM_REQ.size  <= size_q;
      MEM_REQ.space <= (op_q == OP_MWR || op_q == OP_FILL) ? dfc_q : sfc_q;
      MEM_REQ.addr  <= addr_q;
      MEM_REQ.wdata <= result_q;
    end
    else
      MEM_REQ.req <= 1'b0;
  end

  // The answer word is registered before leaving the block.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      XFER_OUT <= `STAT_DONE;
    else
      XFER_OUT <= xfer_out_d;
  end

  // Software status: busy flag and count of command words taken in idle, illegal ones included.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      busy_q      <= 1'b0;
      cmd_count_q <= 32'h0000_0000;
    end
    else
    begin
      busy_q <= (state_q != ST_IDLE);
      if (state_q == ST_IDLE && strobe_pulse)
        cmd_count_q <= cmd_count_q + 32'h0000_0001;
    end
  end

  // Wishbone slave: one wait state, ack dropped the cycle after it is given.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end
    else
    begin
      WB_ACK_O <= WB_CYC_I & WB_STB_I & ~WB_ACK_O;
      unique case (WB_ADR_I)
        `WB_CTRL_OFS: WB_DAT_O <= cmd_count_q;
        `WB_STAT_OFS: WB_DAT_O <= {23'h00_0000, busy_q, err_q, 3'h0, state_q};
        `WB_SCRA_OFS: WB_DAT_O <= scra_q;
        `WB_RPC_OFS:  WB_DAT_O <= rpc_q;
        default:      WB_DAT_O <= 32'h0000_0000;
      endcase
    end
  end

  // Assertions.
  property p_done_after_core_write;
    @(posedge CLK) disable iff (!RST_B)
    (state_q == ST_OPB && strobe_pulse && op_q == OP_WCORE) |-> ##2 XFER_OUT == `STAT_DONE;
  endproperty
  a_done_after_core_write: assert property (p_done_after_core_write)
    else $error("core write did not answer done");

  property p_err_status;
    @(posedge CLK) disable iff (!RST_B)
    (state_q == ST_MEM && MEM_RSP.err) |-> ##2 XFER_OUT == `STAT_BUSERR;
  endproperty
  a_err_status: assert property (p_err_status)
    else $error("bus error status wrong");

  property p_ptr_step;
    @(posedge CLK) disable iff (!RST_B)
    (state_q == ST_MEM && MEM_RSP.ack && !MEM_RSP.err)
      |=> scra_q == $past(addr_q) + size_step($past(size_q));
  endproperty
  a_ptr_step: assert property (p_ptr_step)
    else $error("pointer not advanced by size");

  property p_fault_ro;
    @(posedge CLK) disable iff (!RST_B)
    (op_q == OP_WSYS && sel_q == `SREG_FAULT && state_q == ST_OPB) |=> $stable(fault_q);
  endproperty
  a_fault_ro: assert property (p_fault_ro)
    else $error("fault address written");

  property p_space_rd;
    @(posedge CLK) disable iff (!RST_B)
    (MEM_REQ.req && !MEM_REQ.we) |-> MEM_REQ.space == sfc_q;
  endproperty
  a_space_rd: assert property (p_space_rd)
    else $error("read space not from source code");

  property p_space_wr;
    @(posedge CLK) disable iff (!RST_B)
    (MEM_REQ.req && MEM_REQ.we) |-> MEM_REQ.space == dfc_q;
  endproperty
  a_space_wr: assert property (p_space_wr)
    else $error("write space not from destination code");

  property p_byte_zero;
    @(posedge CLK) disable iff (!RST_B)
    (state_q == ST_MEM && MEM_RSP.ack && !MEM_RSP.err && size_q == `SZ_BYTE && !MEM_REQ.we)
      |=> result_q[31:8] == 24'h00_0000;
  endproperty
  a_byte_zero: assert property (p_byte_zero)
    else $error("byte read upper bits not zero");

  property p_core_write;
    @(posedge CLK) disable iff (!RST_B)
    (state_q == ST_OPB && strobe_pulse && op_q == OP_WCORE)
      |=> core_q[$past(sel_q)] == $past(op_data);
  endproperty
  a_core_write: assert property (p_core_write)
    else $error("core register not fully written");
endmodule
`default_nettype wire

// ===== design/dbg_link_sync.sv
// Two-stage synchroniser with edge detection for the serial link strobe.
`timescale 1ns/100ps
`default_nettype none
module dbg_link_sync
(
  input  wire logic CLK,
  input  wire logic RST_B,
  input  wire logic async_in,
  output var  logic rise_pulse
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  // The first stage feeds only the second, so metastability stays contained.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // A rising edge of the settled level marks one arrived transfer.
  assign rise_pulse = sync_q & ~last_q;
endmodule
`default_nettype wire

// ===== shared/dbg_cmd_cfg.svh
// Constants for the debug command execution block.
`ifndef DBG_CMD_CFG_SVH
`define DBG_CMD_CFG_SVH
`define WB_CTRL_OFS      8'h00
`define WB_STAT_OFS      8'h04
`define WB_SCRA_OFS      8'h08
`define WB_RPC_OFS       8'h0C
`define CMD_RCORE_HI     12'h218
`define CMD_WCORE_HI     12'h208
// The read code differs from the write code in bit 8, so the two decode apart.
`define CMD_RSYS_HI      12'h258
`define CMD_WSYS_HI      12'h0248
`define CMD_MRD_HI       8'h19
`define CMD_MWR_HI       8'h18
`define CMD_DUMP_HI      8'h1D
`define CMD_FILL_HI      8'h1C
`define STAT_DONE        17'h0_FFFF
`define STAT_BUSERR      17'h1_0001
`define STAT_NOTREADY    17'h1_0000
`define STAT_ILLEGAL     17'h1_FFFF
`define SREG_RPC         4'h0
`define SREG_PCC         4'h1
`define SREG_SCRA        4'h8
`define SREG_FAULT       4'h9
`define SREG_VBASE       4'hA
`define SREG_PSW         4'hB
`define SREG_USP         4'hC
`define SREG_SSP         4'hD
`define SREG_SFC         4'hE
`define SREG_DFC         4'hF
`define SZ_BYTE          2'h0
`define SZ_WORD          2'h1
`define SZ_LONG          2'h2
`define BUS_TIMEOUT      8'h40
`endif

// ===== shared/dbg_cmd_pkg.sv
// Types shared by the debug command execution block.
package dbg_cmd_pkg;
  typedef struct packed
  {
    logic        valid;
    logic [16:0] word;
  } xfer_t;
  typedef struct packed
  {
    logic        req;
    logic        we;
    logic [1:0]  size;
    logic [2:0]  space;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_t;
  typedef struct packed
  {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } mem_rsp_t;
  typedef enum logic [3:0]
  {
    ST_IDLE  = 4'b0000,
    ST_OPA   = 4'b0001,
    ST_OPB   = 4'b0010,
    ST_OPC   = 4'b0011,
    ST_OPD   = 4'b0100,
    ST_MEM   = 4'b0101,
    ST_RESHI = 4'b0110,
    ST_RESLO = 4'b0111
  } cmd_state_t;
  typedef enum logic [3:0]
  {
    OP_NONE  = 4'b0000,
    OP_RCORE = 4'b0001,
    OP_WCORE = 4'b0010,
    OP_RSYS  = 4'b0011,
    OP_WSYS  = 4'b0100,
    OP_MRD   = 4'b0101,
    OP_MWR   = 4'b0110,
    OP_DUMP  = 4'b0111,
    OP_FILL  = 4'b1000
  } cmd_op_t;
endpackage

// ===== verification/host_link_model.sv
// Host side of the serial debug link: sends one 17-bit word per frame.
`timescale 1ns/100ps
`default_nettype none
module host_link_model
(
  input  wire logic        CLK,
  input  wire logic [16:0] ANS,
  output var  logic        STROBE,
  output var  logic [16:0] WORD
);
  // The link clock stands low between frames.
  initial
  begin
    STROBE = 1'b0;
    WORD   = 17'h0_0000;
  end
  // Half of the 320 ns link period high, half low, then an idle gap so the answer can load.
  // The answer of the previous word is taken as the frame starts.
  task automatic xfer(input logic [16:0] w, output logic [16:0] r);
    @(posedge CLK);
    r = ANS;
    STROBE <= 1'b1;
    WORD   <= w;
    repeat (4) @(posedge CLK);
    STROBE <= 1'b0;
    repeat (4) @(posedge CLK);
    WORD <= ~w; // A released line shows no stale value.
    repeat (8) @(posedge CLK);
  endtask
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for the debug command executor.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; \
  $display("ERROR %0t got %h want %h", $time, (a), (e)); end end
module testbench;
  import dbg_cmd_pkg::*;
  logic        clk;
  logic        rst_b;
  logic        strobe;
  logic        cyc;
  logic        stb;
  logic        we;
  logic        ack;
  logic [16:0] xin;
  logic [16:0] xout;
  logic [16:0] r;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] q;
  mem_req_t    mreq;
  mem_req_t    seen;
  mem_rsp_t    mrsp;
  int          n_errors;
  int          checks;
  int          lat;
  int          cnt;
  always #20 clk = ~clk;
  dbg_cmd_exec dut (.CLK(clk), .RST_B(rst_b), .XFER_STROBE(strobe), .XFER_IN(xin),
    .XFER_OUT(xout), .MEM_REQ(mreq), .MEM_RSP(mrsp), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack));
  host_link_model host (.CLK(clk), .ANS(xout), .STROBE(strobe), .WORD(xin));
  // Memory stand-in: answers after lat cycles; top nibble E gives a bus error.
  always @(posedge clk)
  begin
    mrsp.ack <= 1'b0;
    mrsp.err <= 1'b0;
    mrsp.rdata <= ~mrsp.rdata;
    if (!mreq.req)
      cnt <= 0;
    else if (cnt < lat)
      cnt <= cnt + 1;
    else if (cnt == lat)
    begin
      mrsp.ack <= mreq.addr[31:28] != 4'hE;
      mrsp.err <= mreq.addr[31:28] == 4'hE;
      mrsp.rdata <= ~mreq.addr;
      seen <= mreq;
      cnt <= cnt + 1;
    end
  end
  task give_verdict;
    if (n_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task lost;
    n_errors++;
    $display("ERROR %0t no answer", $time);
    give_verdict;
  endtask
  // Classic single Wishbone cycle, held until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (i = 0; i < 20 && ack !== 1'b1; i++)
      @(posedge clk);
    if (i == 20)
      lost;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic x(input logic [16:0] w);
    host.xfer(w, r);
  endtask
  // Polls with no-ops while the memory access is still running.
  task automatic getr;
    int i;
    x(17'h0_0000);
    for (i = 0; i < 20 && r === 17'h1_0000; i++)
      x(17'h0_0000);
    if (i == 20)
      lost;
  endtask
  task automatic rd_op(input logic dump, input logic [1:0] sz, input logic [31:0] a);
    logic [31:0] e;
    e = ~a;
    x({1'b0, dump ? 8'h1D : 8'h19, sz, 6'h00});
    if (!dump)
    begin
      x({1'b0, a[31:16]});
      x({1'b0, a[15:0]});
    end
    getr;
    `CHK({seen.we, seen.size, seen.addr}, {1'b0, sz, a})
    if (a[31:28] == 4'hE)
      `CHK(r, 17'h1_0001)
    else if (sz == 2'h2)
    begin
      `CHK(r, {1'b0, e[31:16]})
      x(17'h0_0000);
      `CHK(r, {1'b0, e[15:0]})
    end
    else
      `CHK(r, {1'b0, sz[0] ? e[15:8] : 8'h00, e[7:0]})
  endtask
  task automatic wr_op(input logic fill, input logic [1:0] sz, input logic [31:0] a,
                       input logic [31:0] d);
    logic [31:0] m;
    m = sz == 2'h2 ? 32'hFFFF_FFFF : (sz == 2'h1 ? 32'h0000_FFFF : 32'h0000_00FF);
    x({1'b0, fill ? 8'h1C : 8'h18, sz, 6'h00});
    if (!fill)
    begin
      x({1'b0, a[31:16]});
      x({1'b0, a[15:0]});
    end
    if (sz == 2'h2)
      x({1'b0, d[31:16]});
    x({1'b0, d[15:0] & m[15:0]});
    getr;
    `CHK({seen.we, seen.size, seen.addr}, {1'b1, sz, a})
    if (a[31:28] == 4'hE)
      `CHK(r, 17'h1_0001)
    else
    begin
      `CHK(seen.wdata & m, d & m)
      `CHK(r, 17'h0_FFFF)
    end
  endtask
  // Every address and data register written, then read back high word first.
  task automatic t_core;
    logic [31:0] v;
    for (int i = 0; i < 16; i++)
    begin
      v = 32'hA5C3_0F00 + 32'h1111_1111 * 32'(i);
      x({1'b0, 16'h2080 | 16'(i)});
      x({1'b0, v[31:16]});
      x({1'b0, v[15:0]});
      x(17'h0_0000);
      `CHK(r, 17'h0_FFFF)
    end
    for (int i = 0; i < 16; i++)
    begin
      v = 32'hA5C3_0F00 + 32'h1111_1111 * 32'(i);
      x({1'b0, 16'h2180 | 16'(i)});
      x(17'h0_0000);
      `CHK(r, {1'b0, v[31:16]})
      x(17'h0_0000);
      `CHK(r, {1'b0, v[15:0]})
    end
  endtask
  // A memory read word with a non-zero low field is not a valid command.
  task automatic t_illegal;
    x(17'h0_1901);
    x(17'h0_0000);
    `CHK(r, 17'h1_FFFF)
  endtask
  // Read then dumps of changing size, a no-op between, a slow memory and an error.
  task automatic t_dump;
    rd_op(1'b0, 2'h2, 32'h0000_1000);
    rd_op(1'b1, 2'h0, 32'h0000_1004);
    rd_op(1'b1, 2'h1, 32'h0000_1005);
    x(17'h0_0000);
    rd_op(1'b1, 2'h2, 32'h0000_1007);
    wb(1'b1, 8'h08, 32'h0000_0000);
    wb(1'b0, 8'h08, 32'h0000_0000);
    `CHK(q, 32'h0000_100B)
    wb(1'b0, 8'h10, 32'h0000_0000);
    `CHK(q, 32'h0000_0000)
    lat = 40;
    rd_op(1'b0, 2'h1, 32'hDFFF_FFFE);
    rd_op(1'b1, 2'h1, 32'hE000_0000);
    lat = 2;
    rd_op(1'b0, 2'h0, 32'h0000_3003);
  endtask
  // Write then fills of changing size, and a write that faults.
  task automatic t_fill;
    wr_op(1'b0, 2'h1, 32'h0000_2000, 32'h0000_BEEF);
    wr_op(1'b1, 2'h0, 32'h0000_2002, 32'h0000_005A);
    wr_op(1'b1, 2'h2, 32'h0000_2003, 32'hCAFE_F00D);
    wr_op(1'b0, 2'h2, 32'hE000_0010, 32'h1234_5678);
  endtask
  // Writes a system register with a long operand and expects the done status.
  task automatic ws(input logic [3:0] s, input logic [31:0] v);
    x({1'b0, 12'h248, s});
    x({1'b0, v[31:16]});
    x({1'b0, v[15:0]});
    x(17'h0_0000);
    `CHK(r, 17'h0_FFFF)
  endtask
  // Reads a system register and expects the high word, then the low word.
  task automatic rs(input logic [3:0] s, input logic [31:0] e);
    x({1'b0, 12'h258, s});
    x(17'h0_0000);
    `CHK(r, {1'b0, e[31:16]})
    x(17'h0_0000);
    `CHK(r, {1'b0, e[15:0]})
  endtask
  // Full width registers at their own codes, narrow ones, the read-only fault address.
  task automatic t_sys;
    for (int i = 0; i < 14; i++)
      if (i < 2 || i == 10 || i == 12 || i == 13)
        ws(4'(i), {8'h93, 4'(i), 20'h5_A61C});
    for (int i = 0; i < 14; i++)
      if (i < 2 || i == 10 || i == 12 || i == 13)
        rs(4'(i), {8'h93, 4'(i), 20'h5_A61C});
    ws(4'hB, 32'hFFFF_A5A5);
    rs(4'hB, 32'h0000_A5A5);
    ws(4'hE, 32'h0000_0005);
    ws(4'hF, 32'h0000_0003);
    rs(4'hE, 32'h0000_0005);
    ws(4'h9, 32'h0BAD_F00D);
    rs(4'h9, 32'hE000_0010);
    rd_op(1'b0, 2'h1, 32'h0000_4000);
    `CHK(seen.space, 3'h5)
    rs(4'h8, 32'h0000_4002);
    wr_op(1'b0, 2'h0, 32'h0000_5000, 32'h0000_00C3);
    `CHK(seen.space, 3'h3)
    wb(1'b0, 8'h0C, 32'h0000_0000);
    `CHK(q, 32'h9305_A61C)
  endtask
  initial
  begin
    clk = 1'b0;
    rst_b = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0000_0000;
    mrsp = '0;
    lat = 2;
    cnt = 0;
    n_errors = 0;
    checks = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    t_core;
    t_illegal;
    t_dump;
    t_fill;
    t_sys;
    give_verdict;
  end
  // Cuts a hang short.
  initial
  begin
    repeat (100000) @(posedge clk);
    lost;
  end
endmodule
`default_nettype wire
